// file: pkg/pcicf_pkg.sv
// Constants, field layouts and carriers for the function-one configuration header.
// Assumes a PCI bus clock domain and byte addressing of {AD[7:2], 00} for the header.
package pcicf_pkg;

    // Byte offsets of the header dwords.
    localparam logic [7:0] OFS_IDENT = 8'h00;
    localparam logic [7:0] OFS_CMDSTAT = 8'h04;
    localparam logic [7:0] OFS_CLASS = 8'h08;
    localparam logic [7:0] OFS_HDRLAT = 8'h0c;
    localparam logic [7:0] OFS_BAR = 8'h10;
    localparam logic [7:0] OFS_SUBSYS = 8'h20;

    // Function number that selects this header on AD[10:8].
    localparam logic [2:0] FUNC_NUM = 3'h1;

    // Command word fields.
    localparam int CMD_MEM = 1;
    localparam int CMD_MASTER = 2;
    localparam int CMD_PERR = 6;
    localparam int CMD_SERR = 8;
    localparam logic [15:0] CMD_RW_MASK = 16'h0146;
    localparam logic [15:0] CMD_RESET = 16'h0000;

    // Sticky status flags, as bit positions of the whole dword.
    localparam int NUM_FLAGS = 6;
    localparam int FL_DPE = 0;
    localparam int FL_SSE = 1;
    localparam int FL_RMA = 2;
    localparam int FL_RTA = 3;
    localparam int FL_STA = 4;
    localparam int FL_DPR = 5;
    localparam int FLAG_POS [NUM_FLAGS] = '{31, 30, 29, 28, 27, 24};

    // Fixed status fields.
    localparam int DEVSEL_LSB = 25;
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam int FB2B_POS = 23;

    // Fixed identification and layout values.
    localparam logic [23:0] CLASS_CODE = 24'h048000;
    localparam logic [7:0] HEADER_TYPE = 8'h80;
    localparam int HDR_LSB = 16;
    localparam int LAT_LSB = 8;
    localparam logic [7:0] LAT_RESET = 8'h00;
    localparam int BAR_LSB = 12;
    localparam logic [11:0] BAR_LOW = 12'h008;
    localparam logic [19:0] BAR_RESET = 20'h00000;

    // One configuration data phase, as seen by the header.
    typedef struct packed {
        logic valid;
        logic idsel;
        logic [10:0] addr;
        logic write;
        logic [3:0] be_n;
        logic [31:0] wdata;
    } pcicf_cfg_req_t;

    // Bus events reported by the PCI engine, each a one-cycle pulse.
    typedef struct packed {
        logic addr_perr;
        logic data_perr;
        logic tgt_addr_perr;
        logic master_abort;
        logic target_abort_rcvd;
        logic mst_rd_perr_driven;
        logic mst_wr_perr_seen;
        logic sys_err_req;
    } pcicf_evt_t;

endpackage : pcicf_pkg

// file: core/pcicf_sticky_flag.sv
// One write-one-to-clear status flag.
// Assumes set and clear are pulses in the bus clock domain and reset is already synchronised.
`timescale 1ns/10ps
module pcicf_sticky_flag (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic set,
    input wire logic clear,
    output logic q
);

    // write one clears.
    // A set in the same cycle as a clear wins, so no event is lost to software.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clear) begin
            q <= 1'b0;
        end
    end

    a_set_wins: assert property (
        @(posedge clk) disable iff (!rst_n)
        set |=> q)
        else $error("Status flag lost an event.");

endmodule : pcicf_sticky_flag

// file: core/pcicf_header.sv
// Configuration header of the multimedia function, with its command and status logic.
// Assumes the PCI engine decodes bus phases into config requests and event pulses.
`timescale 1ns/10ps
module pcicf_header #(
    parameter logic [15:0] MAKER_ID = 16'h1a2b, // Arbitrary value.
    parameter logic [15:0] PART_ID = 16'h3c4d, // Arbitrary value.
    parameter logic [7:0] REVISION_ID = 8'h02, // Arbitrary value.
    parameter logic [15:0] SUBSYS_VENDOR_ID = 16'h5e6f, // Arbitrary value.
    parameter logic [15:0] SUBSYS_ID = 16'h7a8b // Arbitrary value.
) (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire pcicf_pkg::pcicf_cfg_req_t CFG_REQ,
    output logic CFG_ACK,
    output logic [31:0] CFG_RDATA,
    input wire pcicf_pkg::pcicf_evt_t EVT,
    input wire logic MEM_CYCLE,
    input wire logic [31:0] MEM_ADDR,
    output logic MEM_HIT,
    output logic MASTER_EN,
    output logic PERR_REPORT_EN,
    output logic TGT_ABORT,
    output logic SERR_O,
    output logic SERR_OE_N,
    input wire logic MST_START,
    input wire logic MST_ACTIVE,
    input wire logic GNT_N,
    output logic MST_TERMINATE
);

    logic rst_meta;
    logic rst_n;
    logic [15:0] cmd;
    logic [7:0] lat_timer;
    logic [19:0] bar_ptr;
    logic [31:0] bar_merged;
    logic [7:0] lat_count;
    logic serr_drive;
    logic tgt_abort;
    logic cfg_claim;
    logic cfg_wr;
    logic [31:0] wmask;
    logic [7:0] byte_addr;
    logic [31:0] status_word;
    logic [31:0] next_rdata;
    logic [pcicf_pkg::NUM_FLAGS-1:0] flag_set;
    logic [pcicf_pkg::NUM_FLAGS-1:0] flag_clr;
    logic [pcicf_pkg::NUM_FLAGS-1:0] flag;

    // Expands active-low byte enables into a bit mask of written lanes.
    function automatic logic [31:0] lane_mask(input logic [3:0] be_n);
        logic [31:0] m;
        m = 32'h00000000;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{~be_n[b]}};
        end
        return m;
    endfunction : lane_mask

    // Merges write data into a register under a lane and field mask.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
        return (old & ~m) | (wd & m);
    endfunction : merge

    // The reset is released through two flops so that removal is clean against the clock.
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // relies on function number; the other function's header ignores these cycles.
    assign cfg_claim = CFG_REQ.valid && CFG_REQ.idsel && (CFG_REQ.addr[1:0] == 2'h0)
        && (CFG_REQ.addr[10:8] == pcicf_pkg::FUNC_NUM);
    assign cfg_wr = cfg_claim && CFG_REQ.write;
    assign wmask = lane_mask(CFG_REQ.be_n);
    assign byte_addr = {CFG_REQ.addr[7:2], 2'h0};

    // parity response bit.
    // Only the four defined bits are held; the rest are never stored, so they cannot read back.
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            cmd <= pcicf_pkg::CMD_RESET;
        end else if (cfg_wr && byte_addr == pcicf_pkg::OFS_CMDSTAT) begin
            cmd <= 16'(merge({16'h0000, cmd}, CFG_REQ.wdata, wmask & {16'h0000, pcicf_pkg::CMD_RW_MASK}));
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            lat_timer <= pcicf_pkg::LAT_RESET;
        end else if (cfg_wr && byte_addr == pcicf_pkg::OFS_HDRLAT && !CFG_REQ.be_n[1]) begin
            lat_timer <= CFG_REQ.wdata[pcicf_pkg::LAT_LSB +: 8];
        end
    end

    // The merged dword is formed apart, since a function result cannot be sliced in place.
    assign bar_merged = merge({bar_ptr, 12'h000}, CFG_REQ.wdata, wmask);

    // relocatable pointer.
    // The low twelve bits are constants, so a 4 kB window is always naturally aligned.
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            bar_ptr <= pcicf_pkg::BAR_RESET;
        end else if (cfg_wr && byte_addr == pcicf_pkg::OFS_BAR) begin
            bar_ptr <= bar_merged[31:pcicf_pkg::BAR_LSB];
        end
    end

    assign MEM_HIT = MEM_CYCLE && cmd[pcicf_pkg::CMD_MEM] && (MEM_ADDR[31:pcicf_pkg::BAR_LSB] == bar_ptr);

    assign MASTER_EN = cmd[pcicf_pkg::CMD_MASTER];
    assign PERR_REPORT_EN = cmd[pcicf_pkg::CMD_PERR];

    // system error drive.
    // An address parity error raises the error pin only when both enables are on.
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            serr_drive <= 1'b0;
        end else begin
            serr_drive <= cmd[pcicf_pkg::CMD_SERR]
                && ((EVT.addr_perr && cmd[pcicf_pkg::CMD_PERR]) || EVT.sys_err_req);
        end
    end

    // The pin is open drain: it only ever pulls low, and the enable is low while pulling.
    assign SERR_O = 1'b0;
    assign SERR_OE_N = ~serr_drive;

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            tgt_abort <= 1'b0;
        end else begin
            tgt_abort <= EVT.tgt_addr_perr;
        end
    end

    assign TGT_ABORT = tgt_abort;

    always_comb begin
        flag_set = '0;
        flag_set[pcicf_pkg::FL_DPE] = EVT.addr_perr || EVT.data_perr || EVT.tgt_addr_perr;
        flag_set[pcicf_pkg::FL_SSE] = serr_drive;
        flag_set[pcicf_pkg::FL_RMA] = EVT.master_abort;
        flag_set[pcicf_pkg::FL_RTA] = EVT.target_abort_rcvd;
        flag_set[pcicf_pkg::FL_STA] = tgt_abort;
        flag_set[pcicf_pkg::FL_DPR] = cmd[pcicf_pkg::CMD_PERR]
            && (EVT.mst_rd_perr_driven || EVT.mst_wr_perr_seen);
    end

    genvar gi;
    generate
        for (gi = 0; gi < pcicf_pkg::NUM_FLAGS; gi++) begin : g_flag
            assign flag_clr[gi] = cfg_wr && byte_addr == pcicf_pkg::OFS_CMDSTAT
                && wmask[pcicf_pkg::FLAG_POS[gi]] && CFG_REQ.wdata[pcicf_pkg::FLAG_POS[gi]];
            pcicf_sticky_flag u_flag (
                .clk(CLK_SYS),
                .rst_n(rst_n),
                .set(flag_set[gi]),
                .clear(flag_clr[gi]),
                .q(flag[gi])
            );
        end
    endgenerate

    always_comb begin
        status_word = {16'h0000, cmd};
        for (int i = 0; i < pcicf_pkg::NUM_FLAGS; i++) begin
            status_word[pcicf_pkg::FLAG_POS[i]] = flag[i];
        end
        status_word[pcicf_pkg::DEVSEL_LSB +: 2] = pcicf_pkg::DEVSEL_MEDIUM;
        status_word[pcicf_pkg::FB2B_POS] = 1'b1;
    end

    always_comb begin
        next_rdata = 32'h00000000;
        if (!CFG_REQ.write) begin
            case (byte_addr)
                pcicf_pkg::OFS_IDENT: next_rdata = {PART_ID, MAKER_ID};
                pcicf_pkg::OFS_CMDSTAT: next_rdata = status_word;
                pcicf_pkg::OFS_CLASS: next_rdata = {pcicf_pkg::CLASS_CODE, REVISION_ID};
                pcicf_pkg::OFS_HDRLAT: next_rdata = {8'h00, pcicf_pkg::HEADER_TYPE, lat_timer, 8'h00};
                pcicf_pkg::OFS_BAR: next_rdata = {bar_ptr, pcicf_pkg::BAR_LOW};
                pcicf_pkg::OFS_SUBSYS: next_rdata = {SUBSYS_ID, SUBSYS_VENDOR_ID};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    // Every claimed phase, read or write, is answered one cycle later.
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            CFG_ACK <= 1'b0;
            CFG_RDATA <= 32'h00000000;
        end else begin
            CFG_ACK <= cfg_claim;
            if (cfg_claim) begin
                CFG_RDATA <= next_rdata;
            end
        end
    end

    // latency countdown.
    // The counter loads at the start of each tenure and stops at zero, which marks expiry.
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            lat_count <= 8'h00;
        end else if (MST_START) begin
            lat_count <= lat_timer;
        end else if (MST_ACTIVE && lat_count != 8'h00) begin
            lat_count <= lat_count - 8'h01;
        end
    end

    assign MST_TERMINATE = MASTER_EN && MST_ACTIVE && !MST_START && (lat_count == 8'h00) && GNT_N;

    a_claim_needs_idsel: assert property (
        @(posedge CLK_SYS) disable iff (!rst_n)
        CFG_ACK |-> $past(CFG_REQ.idsel) && $past(CFG_REQ.addr[1:0]) == 2'h0
            && $past(CFG_REQ.addr[10:8]) == 3'h1)
        else $error("Config answer without a proper select.");

    a_idle_no_hit: assert property (
        @(posedge CLK_SYS) disable iff (!rst_n)
        (cmd == 16'h0000) |-> !MEM_HIT && !MASTER_EN && SERR_OE_N)
        else $error("Idle command word still connected to the bus.");

    a_cmd_reads_clean: assert property (
        @(posedge CLK_SYS) disable iff (!rst_n)
        CFG_ACK && $past(byte_addr) == pcicf_pkg::OFS_CMDSTAT && !$past(CFG_REQ.write)
        |-> (CFG_RDATA[15:0] & ~pcicf_pkg::CMD_RW_MASK) == 16'h0000)
        else $error("Undefined command bits read as one.");

    a_serr_needs_enable: assert property (
        @(posedge CLK_SYS) disable iff (!rst_n)
        !SERR_OE_N |-> $past(cmd[pcicf_pkg::CMD_SERR]))
        else $error("System error driven while disabled.");

    a_serr_sets_flag: assert property (
        @(posedge CLK_SYS) disable iff (!rst_n)
        !SERR_OE_N |=> flag[pcicf_pkg::FL_SSE])
        else $error("Signalled error flag not set.");

    a_perr_sets_dpe: assert property (
        @(posedge CLK_SYS) disable iff (!rst_n)
        EVT.data_perr || EVT.addr_perr |=> flag[pcicf_pkg::FL_DPE])
        else $error("Detected parity flag not set.");

    a_tabort_sets_sta: assert property (
        @(posedge CLK_SYS) disable iff (!rst_n)
        EVT.tgt_addr_perr |=> TGT_ABORT ##1 flag[pcicf_pkg::FL_STA])
        else $error("Target abort or its flag missing.");

    a_dpr_gated: assert property (
        @(posedge CLK_SYS) disable iff (!rst_n)
        $rose(flag[pcicf_pkg::FL_DPR]) |-> $past(cmd[pcicf_pkg::CMD_PERR]))
        else $error("Parity reported flag set while response disabled.");

    // Bit 24 between the fixed fields is a sticky flag, so only 26:25 and 23 are pinned here.
    a_status_fixed: assert property (
        @(posedge CLK_SYS) disable iff (!rst_n)
        CFG_ACK && $past(byte_addr) == pcicf_pkg::OFS_CMDSTAT && !$past(CFG_REQ.write)
        |-> CFG_RDATA[26:25] == 2'h1 && CFG_RDATA[23] == 1'b1)
        else $error("Fixed status fields are wrong.");

    a_bar_low_fixed: assert property (
        @(posedge CLK_SYS) disable iff (!rst_n)
        CFG_ACK && $past(byte_addr) == pcicf_pkg::OFS_BAR && !$past(CFG_REQ.write)
        |-> CFG_RDATA[11:0] == 12'h008)
        else $error("Base pointer low bits are not fixed.");

    a_lat_expiry: assert property (
        @(posedge CLK_SYS) disable iff (!rst_n)
        MST_TERMINATE |-> lat_count == 8'h00 && GNT_N && MASTER_EN)
        else $error("Master terminated before latency expiry.");

    // The count must start each tenure from the programmed timer, not from a stale value.
    a_lat_load: assert property (
        @(posedge CLK_SYS) disable iff (!rst_n)
        MST_START |=> lat_count == $past(lat_timer))
        else $error("Latency count did not load the timer value.");

    a_hit_needs_decode: assert property (
        @(posedge CLK_SYS) disable iff (!rst_n)
        MEM_HIT |-> cmd[pcicf_pkg::CMD_MEM] && MEM_CYCLE)
        else $error("Memory hit while decode is disabled.");

endmodule : pcicf_header

// file: core/pcicf_placeholder_unused.sv
`timescale 1ns/10ps
// Empty leaf reserved; intentionally holds no module.

// file: verif/pcicf_host_model.sv
// Host bridge model that issues decoded configuration data phases to the header.
// Assumes the header answers on the edge that takes a phase and holds the answer for exactly one cycle.
`timescale 1ns/10ps
module pcicf_host_model (
    input wire logic clk,
    output pcicf_pkg::pcicf_cfg_req_t req,
    input wire logic ack,
    input wire logic [31:0] rdata
);
    // The bus starts idle.
    initial begin
        req = '0;
    end

    // One phase is driven just after an edge and taken at the next one.
    // On release the address and data lines carry inverted values, so stale data can never pass for fresh.
    // select and function
    task automatic cfg(input logic wr, input logic sel, input logic [2:0] fn, input logic [7:0] ofs,
                       input logic [3:0] be_n, input logic [31:0] wd, output logic got, output logic [31:0] rd);
        @(posedge clk);
        #1;
        req.valid = 1'h1;
        req.idsel = sel;
        req.addr = {fn, ofs};
        req.write = wr;
        req.be_n = be_n;
        req.wdata = wd;
        @(posedge clk);
        #1;
        req.valid = 1'h0;
        req.addr = ~req.addr;
        req.wdata = ~req.wdata;
        got = ack;
        rd = rdata;
        @(posedge clk);
        #1;
        // An answer that stands longer than one cycle is not accepted.
        got = got & ~ack;
    endtask : cfg
endmodule : pcicf_host_model

// file: verif/tb_top.sv
// Self-checking bench for the function-one configuration header.
// Assumes the host model issues config phases; events and master inputs come from here.
`timescale 1ns/10ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e); end end
module tb_top;
    typedef struct packed {
        logic wr;
        logic [7:0] ofs;
        logic [3:0] be_n;
        logic [31:0] wd;
        logic [31:0] exp;
    } pcicf_tb_reg_t;
    typedef struct packed {
        logic [15:0] cmd;
        logic [7:0] evt;
        logic [31:0] mask;
        logic [31:0] exp;
    } pcicf_tb_evt_t;

    // Accesses beside the read data, or zero for a write, that each should return.
    localparam pcicf_tb_reg_t REG_ROWS [18] = '{
        '{1'h0, 8'h00, 4'h0, 32'h0, 32'h3c4d1a2b}, '{1'h0, 8'h04, 4'h0, 32'h0, 32'h02800000},
        '{1'h0, 8'h08, 4'h0, 32'h0, 32'h04800002}, '{1'h0, 8'h0c, 4'h0, 32'h0, 32'h00800000},
        '{1'h0, 8'h10, 4'h0, 32'h0, 32'h00000008}, '{1'h0, 8'h20, 4'h0, 32'h0, 32'h7a8b5e6f},
        '{1'h0, 8'h24, 4'h0, 32'h0, 32'h0}, '{1'h1, 8'h00, 4'h0, 32'hffffffff, 32'h0},
        '{1'h1, 8'h08, 4'h0, 32'hffffffff, 32'h0}, '{1'h1, 8'h20, 4'h0, 32'hffffffff, 32'h0},
        '{1'h1, 8'h10, 4'h0, 32'hffffffff, 32'h0}, '{1'h1, 8'h0c, 4'hd, 32'hffff02ff, 32'h0},
        '{1'h1, 8'h04, 4'h0, 32'h0000ffff, 32'h0}, '{1'h0, 8'h00, 4'h0, 32'h0, 32'h3c4d1a2b},
        '{1'h0, 8'h20, 4'h0, 32'h0, 32'h7a8b5e6f}, '{1'h0, 8'h10, 4'h0, 32'h0, 32'hfffff008},
        '{1'h0, 8'h0c, 4'h0, 32'h0, 32'h00800200}, '{1'h0, 8'h04, 4'h0, 32'h0, 32'h02800146}};

    // Command value, event pulse, flags looked at, and flags expected set.
    localparam pcicf_tb_evt_t EVT_ROWS [11] = '{
        '{16'h0146, 8'h40, 32'hf9000000, 32'h80000000}, '{16'h0146, 8'h10, 32'hf9000000, 32'h20000000},
        '{16'h0146, 8'h08, 32'hf9000000, 32'h10000000}, '{16'h0146, 8'h20, 32'hf9000000, 32'h88000000},
        '{16'h0146, 8'h04, 32'h01000000, 32'h01000000}, '{16'h0146, 8'h02, 32'h01000000, 32'h01000000},
        '{16'h0146, 8'h01, 32'hf9000000, 32'h40000000}, '{16'h0146, 8'h80, 32'hf9000000, 32'hc0000000},
        '{16'h0106, 8'h04, 32'h01000000, 32'h0}, '{16'h0106, 8'h80, 32'hf9000000, 32'h80000000},
        '{16'h0046, 8'h01, 32'hf9000000, 32'h0}};

    logic clk, arst_n, mem_cycle, mst_start, mst_active, gnt_n, got;
    logic cfg_ack, mem_hit, master_en, perr_en, tgt_abort, serr_o, serr_oe_n, mst_term;
    logic [31:0] mem_addr, cfg_rdata, rd;
    pcicf_pkg::pcicf_evt_t evt;
    pcicf_pkg::pcicf_cfg_req_t cfg_req;
    int error_cnt, checks, serr_cnt, tabt_cnt;

    pcicf_host_model host_u (.clk(clk), .req(cfg_req), .ack(cfg_ack), .rdata(cfg_rdata));

    pcicf_header dut_u (
        .CLK_SYS(clk), .ARST_N(arst_n), .CFG_REQ(cfg_req), .CFG_ACK(cfg_ack), .CFG_RDATA(cfg_rdata),
        .EVT(evt), .MEM_CYCLE(mem_cycle), .MEM_ADDR(mem_addr), .MEM_HIT(mem_hit), .MASTER_EN(master_en),
        .PERR_REPORT_EN(perr_en), .TGT_ABORT(tgt_abort), .SERR_O(serr_o), .SERR_OE_N(serr_oe_n),
        .MST_START(mst_start), .MST_ACTIVE(mst_active), .GNT_N(gnt_n), .MST_TERMINATE(mst_term));

    // The 25 MHz bus clock.
    always #20 clk = ~clk;

    // Pulse counters for the system error pin and target abort; one pulse per cause is expected.
    always @(negedge clk) begin
        if (serr_oe_n === 1'h0) serr_cnt++;
        if (tgt_abort === 1'h1) tabt_cnt++;
    end

    // Inputs move one nanosecond after the edge, clear of the sampling instant.
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    // Claimed access to this function's header.
    task automatic rw(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        host_u.cfg(wr, 1'h1, 3'h1, ofs, 4'h0, wd, got, rd);
    endtask : rw

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    initial begin
        clk = 1'h0;
        arst_n = 1'h0;
        evt = '0;
        mem_cycle = 1'h0;
        mem_addr = 32'h0;
        mst_start = 1'h0;
        mst_active = 1'h0;
        gnt_n = 1'h1;
        error_cnt = 0;
        checks = 0;
        repeat (4) step();
        `CHK({cfg_ack, master_en, perr_en, serr_oe_n, serr_o}, 5'h02, "reset outputs")
        $display("test reset done");
        arst_n = 1'h1;
        repeat (3) step();
        foreach (REG_ROWS[i]) begin
            host_u.cfg(REG_ROWS[i].wr, 1'h1, 3'h1, REG_ROWS[i].ofs, REG_ROWS[i].be_n, REG_ROWS[i].wd, got, rd);
            `CHK({got, rd}, {1'h1, REG_ROWS[i].exp}, "register row")
        end
        $display("test register rows done");
        foreach (EVT_ROWS[i]) begin
            rw(1'h1, 8'h04, {16'hffff, EVT_ROWS[i].cmd});
            serr_cnt = 0;
            tabt_cnt = 0;
            evt = pcicf_pkg::pcicf_evt_t'(EVT_ROWS[i].evt);
            step();
            evt = '0;
            rw(1'h0, 8'h04, 32'h0);
            `CHK(rd & EVT_ROWS[i].mask, EVT_ROWS[i].exp, "status flags")
            `CHK({serr_cnt[1:0], tabt_cnt[1:0]}, {1'h0, EVT_ROWS[i].exp[30], 1'h0, EVT_ROWS[i].evt[5]}, "pulses")
        end
        $display("test event rows done");
        rw(1'h1, 8'h04, 32'hffff0146);
        evt.master_abort = 1'h1;
        step();
        evt = '0;
        rw(1'h1, 8'h04, 32'hdfff0146);
        rw(1'h0, 8'h04, 32'h0);
        `CHK(rd[29], 1'h1, "zero write kept flag")
        // The event is raised on the same edge that takes the clearing write.
        fork
            host_u.cfg(1'h1, 1'h1, 3'h1, 8'h04, 4'h0, 32'h20000146, got, rd);
            begin
                step();
                evt.master_abort = 1'h1;
                step();
                evt = '0;
            end
        join
        rw(1'h0, 8'h04, 32'h0);
        `CHK(rd[29], 1'h1, "set beats clear")
        rw(1'h1, 8'h04, 32'h20000146);
        rw(1'h0, 8'h04, 32'h0);
        `CHK(rd, 32'h02800146, "one write cleared flag")
        $display("test write one clear done");
        mem_cycle = 1'h1;
        mem_addr = 32'hfffff123;
        #1;
        `CHK({mem_hit, master_en, perr_en}, 3'h7, "decode enabled")
        mem_addr = 32'hffffe123;
        #1;
        `CHK(mem_hit, 1'h0, "decode miss")
        mem_addr = 32'hfffff123;
        mst_start = 1'h1;
        mst_active = 1'h1;
        step();
        mst_start = 1'h0;
        for (int k = 0; k < 3; k++) begin
            #1;
            `CHK(mst_term, k == 2, "latency count")
            step();
        end
        gnt_n = 1'h0;
        #1;
        `CHK(mst_term, 1'h0, "grant still held")
        gnt_n = 1'h1;
        rw(1'h1, 8'h04, 32'h0);
        `CHK({mem_hit, master_en, mst_term}, 3'h0, "all-zero command")
        mst_active = 1'h0;
        $display("test decode and master done");
        for (int k = 0; k < 3; k++) begin
            host_u.cfg(1'h1, k != 0, (k == 1) ? 3'h0 : 3'h1, (k == 2) ? 8'h11 : 8'h10, 4'h0, 32'h0, got, rd);
            `CHK(got, 1'h0, "unclaimed phase")
        end
        rw(1'h0, 8'h10, 32'h0);
        `CHK(rd, 32'hfffff008, "pointer untouched")
        $display("test unclaimed phases done");
        arst_n = 1'h0;
        step();
        `CHK({cfg_ack, master_en, perr_en, serr_oe_n, mem_hit}, 5'h02, "second reset")
        arst_n = 1'h1;
        repeat (3) step();
        rw(1'h0, 8'h0c, 32'h0);
        `CHK(rd, 32'h00800000, "latency cleared")
        rw(1'h0, 8'h10, 32'h0);
        `CHK(rd, 32'h00000008, "pointer cleared")
        $display("test second reset done");
        stop_test();
    end
endmodule : tb_top
